// [pcie_cap_consts.svh]
`ifndef PCIE_CAP_CONSTS_SVH
`define PCIE_CAP_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFF_PB_HDR 12'h20C
`define OFF_PB_DATA 12'h214
`define OFF_PB_CAP 12'h218
`define OFF_ACS_HDR 12'h220
`define OFF_ACS_CTL 12'h224
`define OFF_EGRESS 12'h228
`define OFF_LTR_HDR 12'h230

// ----------------------------------------------------------------
// Capability header contents
// ----------------------------------------------------------------
`define ID_PB 16'h0004
`define ID_ACS 16'h000D
`define ID_LTR 16'h0018
`define CAP_VER 4'h1
`define NEXT_PB_UP 12'h230
`define NEXT_PB_DOWN 12'h220
`define NEXT_L1SUB 12'h240

// ----------------------------------------------------------------
// Budget data select indices and field reset values
// ----------------------------------------------------------------
`define SEL_D0_MAX 8'h00
`define SEL_D0_SUST 8'h01
`define RST_BASE_POWER 8'h04
`define RST_SCALE 2'h0
`define RST_SUBSTATE 3'h0
`define RST_PM_STATE 2'h0
`define TYPE_MAXIMUM 3'h7
`define TYPE_SUSTAINED 3'h3
`define RST_RAIL 3'h2
`define RST_SYS_ALLOC 1'h0

// ----------------------------------------------------------------
// Access-control values and write lanes
// ----------------------------------------------------------------
`define ACS_IMPL 7'h7F
`define EGRESS_SIZE 8'h08
`define RST_ACS_EN 7'h00
`define RST_EGRESS 8'h00
`define LANE_ACS_EN 2
`define LANE_EGRESS 0
`define ZERO_WORD 32'h0000_0000

`endif

// [pcie_cap_pkg.sv]
package pcie_cap_pkg;

    // ----------------------------------------------------------------
    // Register word layouts
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [11:0] next_ptr;
        logic [3:0] version;
        logic [15:0] cap_id;
    } ext_hdr_s;

    typedef struct packed {
        logic [10:0] reserved_preserved;
        logic [2:0] rail;
        logic [2:0] cond_type;
        logic [1:0] pm_state;
        logic [2:0] pm_substate;
        logic [1:0] scale;
        logic [7:0] base_power;
    } budget_data_s;

    typedef struct packed {
        logic [30:0] reserved_preserved;
        logic sys_alloc;
    } budget_cap_s;

    typedef struct packed {
        logic [8:0] reserved_preserved_hi;
        logic [6:0] enables;
        logic [7:0] vector_size;
        logic reserved_preserved_lo;
        logic [6:0] implemented;
    } acs_ctl_s;

    typedef struct packed {
        logic [23:0] reserved_preserved;
        logic [7:0] vector;
    } egress_s;

    // ----------------------------------------------------------------
    // Loadable budget entry
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] base_power;
        logic [1:0] scale;
        logic [1:0] pm_state;
    } budget_entry_s;

endpackage

// [rw_field.sv]
module rw_field
    import pcie_cap_pkg::*;
#(
    parameter int W = 8,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic wr_en,
    input wire logic [W-1:0] wdata,
    output logic [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] value;
    } field_s;

    field_s field_ff;
    field_s nxt_field;

    // ----------------------------------------------------------------
    // Next value
    // ----------------------------------------------------------------
    always_comb begin
        nxt_field = field_ff;
        if (wr_en) begin
            nxt_field.value = wdata;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            field_ff.value <= RST;
        end else begin
            field_ff <= nxt_field;
        end
    end

    assign q = field_ff.value;

endmodule

// [pcie_cap_regs.sv]
`include "pcie_cap_consts.svh"

module pcie_cap_regs
    import pcie_cap_pkg::*;
#(
    parameter logic IS_UPSTREAM = 1'b0
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic cfg_req,
    input wire logic cfg_wr,
    input wire logic [11:0] cfg_addr,
    input wire logic [31:0] cfg_wdata,
    input wire logic [3:0] cfg_be,
    output logic cfg_ack,
    output logic [31:0] cfg_rdata,
    input wire logic [7:0] data_select,
    input wire logic init_load,
    input wire logic init_entry,
    input wire logic [7:0] init_base_power,
    input wire logic [1:0] init_scale,
    input wire logic [1:0] init_pm_state,
    input wire logic init_sys_alloc,
    output logic [6:0] acs_enable,
    output logic [7:0] egress_vector
);

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        budget_entry_s max_entry;
        budget_entry_s sust_entry;
        logic sys_alloc;
    } state_s;

    state_s state_ff;
    state_s nxt_state;

    logic [11:0] word_addr;
    logic acs_en_wr;
    logic egress_wr;
    logic [6:0] acs_en_q;
    logic [7:0] egress_q;
    logic [31:0] rd_word;
    ext_hdr_s pb_hdr;
    ext_hdr_s acs_hdr;
    ext_hdr_s ltr_hdr;
    budget_data_s pb_data;
    budget_cap_s pb_cap;
    acs_ctl_s acs_ctl;
    egress_s egress_word;
    budget_entry_s sel_entry;
    acs_ctl_s wr_acs;
    egress_s wr_egress;

    // ----------------------------------------------------------------
    // Address decode and write strobes
    // ----------------------------------------------------------------
    assign word_addr = {cfg_addr[11:2], 2'b00};
    assign wr_acs = cfg_wdata;
    assign wr_egress = cfg_wdata;

    // Only the lane holding each field is written (lane 2 for enables, lane 0 for the vector); reserved lanes are ignored.
    assign acs_en_wr = cfg_req && cfg_wr && !IS_UPSTREAM && (word_addr == `OFF_ACS_CTL)
        && cfg_be[`LANE_ACS_EN];
    assign egress_wr = cfg_req && cfg_wr && !IS_UPSTREAM && (word_addr == `OFF_EGRESS)
        && cfg_be[`LANE_EGRESS];

    // ----------------------------------------------------------------
    // Writable access-control fields
    // ----------------------------------------------------------------
    rw_field #(
        .W($bits(acs_en_q)),
        .RST(`RST_ACS_EN)
    ) u_acs_en (
        .clk(clk),
        .arst_n(arst_n),
        .wr_en(acs_en_wr),
        .wdata(wr_acs.enables),
        .q(acs_en_q)
    );

    rw_field #(
        .W($bits(egress_q)),
        .RST(`RST_EGRESS)
    ) u_egress (
        .clk(clk),
        .arst_n(arst_n),
        .wr_en(egress_wr),
        .wdata(wr_egress.vector),
        .q(egress_q)
    );

    // ----------------------------------------------------------------
    // Register word assembly
    // ----------------------------------------------------------------
    always_comb begin
        pb_hdr.cap_id = `ID_PB;
        pb_hdr.version = `CAP_VER;
        pb_hdr.next_ptr = IS_UPSTREAM ? `NEXT_PB_UP : `NEXT_PB_DOWN;

        acs_hdr.cap_id = `ID_ACS;
        acs_hdr.version = `CAP_VER;
        acs_hdr.next_ptr = `NEXT_L1SUB;

        ltr_hdr.cap_id = `ID_LTR;
        ltr_hdr.version = `CAP_VER;
        ltr_hdr.next_ptr = `NEXT_L1SUB;

        sel_entry = (data_select == `SEL_D0_SUST) ? state_ff.sust_entry : state_ff.max_entry;
        pb_data.reserved_preserved = '0;
        pb_data.base_power = sel_entry.base_power;
        pb_data.scale = sel_entry.scale;
        pb_data.pm_substate = `RST_SUBSTATE;
        pb_data.pm_state = sel_entry.pm_state;
        pb_data.cond_type = (data_select == `SEL_D0_SUST) ? `TYPE_SUSTAINED
            : `TYPE_MAXIMUM;
        pb_data.rail = `RST_RAIL;

        pb_cap.reserved_preserved = '0;
        pb_cap.sys_alloc = state_ff.sys_alloc;

        acs_ctl.reserved_preserved_hi = '0;
        acs_ctl.enables = acs_en_q;
        acs_ctl.vector_size = `EGRESS_SIZE;
        acs_ctl.reserved_preserved_lo = 1'b0;
        acs_ctl.implemented = `ACS_IMPL;

        egress_word.reserved_preserved = '0;
        egress_word.vector = egress_q;
    end

    // ----------------------------------------------------------------
    // Read multiplexer
    // ----------------------------------------------------------------
    always_comb begin
        rd_word = `ZERO_WORD;
        if (word_addr == `OFF_PB_HDR) begin
            rd_word = pb_hdr;
        end else if (word_addr == `OFF_PB_DATA) begin
            if ((data_select == `SEL_D0_MAX) || (data_select == `SEL_D0_SUST)) begin
                rd_word = pb_data;
            end else begin
                rd_word = `ZERO_WORD;
            end
        end else if (word_addr == `OFF_PB_CAP) begin
            rd_word = pb_cap;
        end else if ((word_addr == `OFF_ACS_HDR) && !IS_UPSTREAM) begin
            rd_word = acs_hdr;
        end else if ((word_addr == `OFF_ACS_CTL) && !IS_UPSTREAM) begin
            rd_word = acs_ctl;
        end else if ((word_addr == `OFF_EGRESS) && !IS_UPSTREAM) begin
            rd_word = egress_word;
        end else if ((word_addr == `OFF_LTR_HDR) && IS_UPSTREAM) begin
            rd_word = ltr_hdr;
        end else begin
            rd_word = `ZERO_WORD;
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_state.ack = cfg_req;
        if (cfg_req && !cfg_wr) begin
            nxt_state.rdata = rd_word;
        end else if (cfg_req) begin
            nxt_state.rdata = `ZERO_WORD;
        end
        if (init_load) begin
            if (init_entry) begin
                nxt_state.sust_entry.base_power = init_base_power;
                nxt_state.sust_entry.scale = init_scale;
                nxt_state.sust_entry.pm_state = init_pm_state;
            end else begin
                nxt_state.max_entry.base_power = init_base_power;
                nxt_state.max_entry.scale = init_scale;
                nxt_state.max_entry.pm_state = init_pm_state;
            end
            nxt_state.sys_alloc = init_sys_alloc;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff.ack <= 1'b0;
            state_ff.rdata <= `ZERO_WORD;
            state_ff.max_entry.base_power <= `RST_BASE_POWER;
            state_ff.max_entry.scale <= `RST_SCALE;
            state_ff.max_entry.pm_state <= `RST_PM_STATE;
            state_ff.sust_entry.base_power <= `RST_BASE_POWER;
            state_ff.sust_entry.scale <= `RST_SCALE;
            state_ff.sust_entry.pm_state <= `RST_PM_STATE;
            state_ff.sys_alloc <= `RST_SYS_ALLOC;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign cfg_ack = state_ff.ack;
    assign cfg_rdata = state_ff.rdata;
    assign acs_enable = acs_en_q;
    assign egress_vector = egress_q;

endmodule

// [pcie_cap_regs_chk.sv]
module pcie_cap_regs_chk
    import pcie_cap_pkg::*;
#(
    parameter logic IS_UPSTREAM = 1'b0
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic cfg_req,
    input wire logic cfg_wr,
    input wire logic [11:0] cfg_addr,
    input wire logic [31:0] cfg_wdata,
    input wire logic [3:0] cfg_be,
    input wire logic cfg_ack,
    input wire logic [31:0] cfg_rdata,
    input wire logic [7:0] data_select,
    input wire logic init_load,
    input wire logic init_entry,
    input wire logic [7:0] init_base_power,
    input wire logic [1:0] init_scale,
    input wire logic [1:0] init_pm_state,
    input wire logic init_sys_alloc,
    input wire logic [6:0] acs_enable,
    input wire logic [7:0] egress_vector
);
    logic rd;
    logic wr;
    assign rd = cfg_req & ~cfg_wr;
    assign wr = cfg_req & cfg_wr;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // ----------------------------------------------------------------
    // Configuration port checks.
    // ----------------------------------------------------------------
    AST_ACK_NEXT: assert property (cfg_req |=> cfg_ack) else $error("ack missing");
    AST_ACK_ONLY: assert property (!cfg_req |=> !cfg_ack) else $error("ack without request");
    AST_WR_ZERO: assert property (wr |=> cfg_rdata == 32'h0000_0000)
        else $error("write ack data not zero");
    AST_SEL_ZERO: assert property (rd && cfg_addr[11:2] == 10'h085
        && data_select > 8'h01 |=> cfg_rdata == 32'h0000_0000)
        else $error("unsupported index not zero");
    AST_PB_NEXT: assert property (rd && cfg_addr[11:2] == 10'h083
        |=> cfg_rdata[31:20] == (IS_UPSTREAM ? 12'h230 : 12'h220)) else $error("bad next pointer");
    AST_ACS_READ: assert property (rd && cfg_addr[11:2] == 10'h089 && !IS_UPSTREAM
        |=> cfg_rdata == {9'h000, acs_enable, 16'h087F}) else $error("bad control word");
    AST_EGR_READ: assert property (rd && cfg_addr[11:2] == 10'h08A && !IS_UPSTREAM
        |=> cfg_rdata == {24'h00_0000, egress_vector}) else $error("bad vector read");
    AST_EGR_WRITE: assert property (wr && cfg_addr[11:2] == 10'h08A && cfg_be[0]
        && !IS_UPSTREAM |=> egress_vector == 8'($past(cfg_wdata)))
        else $error("vector not written");
    AST_EGR_HOLD: assert property (!(wr && cfg_addr[11:2] == 10'h08A && cfg_be[0])
        |=> $stable(egress_vector)) else $error("vector changed");
    AST_EN_WRITE: assert property (wr && cfg_addr[11:2] == 10'h089 && cfg_be[2]
        && !IS_UPSTREAM |=> acs_enable == 7'($past(cfg_wdata) >> 16))
        else $error("enables not written");
    AST_EN_HOLD: assert property (!(wr && cfg_addr[11:2] == 10'h089 && cfg_be[2])
        |=> $stable(acs_enable)) else $error("enables changed");
    AST_LTR_HDR: assert property (rd && cfg_addr[11:2] == 10'h08C
        |=> cfg_rdata == (IS_UPSTREAM ? 32'h2401_0018 : 32'h0000_0000)) else $error("bad header");
endmodule

bind pcie_cap_regs pcie_cap_regs_chk #(.IS_UPSTREAM(IS_UPSTREAM)) chk_i (.clk, .arst_n,
    .cfg_req, .cfg_wr, .cfg_addr, .cfg_wdata, .cfg_be, .cfg_ack, .cfg_rdata, .data_select,
    .init_load, .init_entry, .init_base_power, .init_scale, .init_pm_state, .init_sys_alloc,
    .acs_enable, .egress_vector);

// [pcie_cap_regs_tb.sv]
module pcie_cap_regs_tb
    import pcie_cap_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic arst_n, cfg_req, cfg_wr, init_load, init_entry, init_sys_alloc, sa, ack_dn, ack_up;
    logic [11:0] cfg_addr;
    logic [31:0] cfg_wdata, rd_dn, rd_up, r;
    logic [3:0] cfg_be;
    logic [7:0] data_select, init_base_power, eg_dn, eg_up, eg_m;
    logic [1:0] init_scale, init_pm_state;
    logic [6:0] en_dn, en_up, en_m;
    logic [78:0] exp_q[$];
    logic [78:0] e;
    budget_entry_s ent[2];
    int bad_count = 0;
    int n_compared = 0;
    int seed = 50;
    logic [11:0] addrs[9] = '{12'h20C, 12'h214, 12'h218, 12'h220, 12'h224, 12'h228, 12'h230,
        12'h23C, 12'h000};

    pcie_cap_regs #(.IS_UPSTREAM(1'b0)) pcie_cap_regs_i (.clk, .arst_n, .cfg_req, .cfg_wr,
        .cfg_addr, .cfg_wdata, .cfg_be, .cfg_ack(ack_dn), .cfg_rdata(rd_dn), .data_select,
        .init_load, .init_entry, .init_base_power, .init_scale, .init_pm_state, .init_sys_alloc,
        .acs_enable(en_dn), .egress_vector(eg_dn));
    pcie_cap_regs #(.IS_UPSTREAM(1'b1)) pcie_cap_regs_up_i (.clk, .arst_n, .cfg_req, .cfg_wr,
        .cfg_addr, .cfg_wdata, .cfg_be, .cfg_ack(ack_up), .cfg_rdata(rd_up), .data_select,
        .init_load, .init_entry, .init_base_power, .init_scale, .init_pm_state, .init_sys_alloc,
        .acs_enable(en_up), .egress_vector(eg_up));

    initial forever #12.5 clk = ~clk;

    // ----------------------------------------------------------------
    // Expected register contents and bus tasks.
    // ----------------------------------------------------------------
    function automatic logic [31:0] rexp(logic up, logic [11:0] a, logic [7:0] s);
        budget_entry_s b;
        b = ent[s[0]];
        case (a)
            12'h20C: return {up ? 12'h230 : 12'h220, 20'h1_0004};
            12'h214: return (s > 8'h01) ? 32'h0000_0000 : {11'h000, 3'h2, s[0] ? 3'h3 : 3'h7,
                b.pm_state, 3'h0, b.scale, b.base_power};
            12'h218: return {31'h0, sa};
            12'h220: return up ? 32'h0000_0000 : 32'h2401_000D;
            12'h224: return up ? 32'h0000_0000 : {9'h000, en_m, 16'h087F};
            12'h228: return up ? 32'h0000_0000 : {24'h00_0000, eg_m};
            12'h230: return up ? 32'h2401_0018 : 32'h0000_0000;
            default: return 32'h0000_0000;
        endcase
    endfunction

    task automatic acc(logic w, logic [11:0] a, logic [31:0] d, logic [3:0] be, logic [7:0] s);
        @(posedge clk);
        #1;
        {cfg_req, cfg_wr, cfg_addr, cfg_wdata, cfg_be, data_select} = {1'b1, w, a, d, be, s};
        if (w && a == 12'h224 && be[2]) en_m = d[22:16];
        if (w && a == 12'h228 && be[0]) eg_m = d[7:0];
        exp_q.push_back({w ? 64'h0 : {rexp(1'b0, a, s), rexp(1'b1, a, s)}, en_m, eg_m});
    endtask

    task automatic ld(logic k, logic [7:0] bp, logic [1:0] sc, logic [1:0] st, logic a);
        @(posedge clk);
        #1;
        cfg_req = 1'b0;
        {init_load, init_entry, init_base_power, init_scale, init_pm_state, init_sys_alloc} =
            {1'b1, k, bp, sc, st, a};
        ent[k] = '{bp, sc, st};
        sa = a;
        @(posedge clk);
        #1;
        init_load = 1'b0;
    endtask

    task automatic rst(int n);
        @(posedge clk);
        #1;
        cfg_req = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        arst_n = 1'b0;
        repeat (n) @(posedge clk);
        #1;
        arst_n = 1'b1;
        for (int k = 0; k < 2; k++) ent[k] = '{8'h04, 2'h0, 2'h0};
        {sa, en_m, eg_m} = '0;
    endtask

    task automatic finish_test();
        $display("Compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Result watcher, watchdog and main sequence.
    // ----------------------------------------------------------------
    always @(negedge clk) begin
        if (ack_dn === 1'b1 || ack_up === 1'b1) begin
            e = exp_q.size() ? exp_q.pop_front() : 'x;
            n_compared++;
            if ({ack_dn, ack_up, rd_dn, rd_up, en_dn, eg_dn, en_up, eg_up}
                    !== {2'b11, e, 15'h0}) begin
                bad_count++;
                $display("BAD %0t read %h %h expected %h", $time, rd_dn, rd_up, e[78:15]);
            end
        end
    end

    initial begin
        #(25ns * 4000);
        bad_count++;
        $display("BAD %0t watchdog expired", $time);
        finish_test();
    end

    initial begin
        {cfg_req, cfg_wr, cfg_addr, cfg_wdata, cfg_be, data_select} = '0;
        {arst_n, init_load, init_entry, init_base_power, init_scale, init_pm_state} = '0;
        init_sys_alloc = 1'b0;
        rst(7);
        for (int i = 0; i < 27; i++) begin
            acc(0, addrs[i % 9], 0, 0, i > 17 ? 8'hFE : 8'(i / 9));
        end
        acc(1, 12'h228, 32'hFFFF_FFA5, 4'h1, 8'h00);
        acc(1, 12'h224, 32'hFFFF_FFFF, 4'hB, 8'h00);
        acc(1, 12'h224, 32'hFFFF_FFFF, 4'hF, 8'h00);
        acc(1, 12'h214, 32'hFFFF_FFFF, 4'hF, 8'h00);
        for (int i = 0; i < 9; i++) acc(0, addrs[i], 0, 0, 8'h00);
        ld(1'b0, 8'hC3, 2'h2, 2'h3, 1'b1);
        ld(1'b1, 8'h5A, 2'h1, 2'h1, 1'b0);
        for (int i = 0; i < 4; i++) acc(0, i[1] ? 12'h218 : 12'h214, 0, 0, 8'(i[0]));
        for (int i = 0; i < 150; i++) begin
            r = $random(seed);
            if (r[31:28] == 4'h0) ld(r[0], r[15:8], r[3:2], r[5:4], r[6]);
            else acc(r[7], addrs[r[11:8] % 4'd9], $random(seed), r[15:12],
                r[16] ? r[23:16] : {7'h00, r[17]});
        end
        rst(3);
        for (int i = 0; i < 9; i++) acc(0, addrs[i], 0, 0, 8'h00);
        rst(1);
        repeat (3) @(posedge clk);
        if (exp_q.size() != 0) begin
            bad_count++;
            $display("BAD %0t acknowledgements missing", $time);
        end
        finish_test();
    end
endmodule
